//--- inc/nibble_core_pkg.sv
// Constants, opcodes and carrier types for the nibble core decoder.
// Assumes a single 50 MHz clock and external program memory.
// How it works
// - 90 instructions: 40 one-byte/one-cycle, 11 one-byte/two-cycle, 39 two-byte/two-cycle.
// - Indirect data address is high pointer nibble over low pointer nibble.
// - Opcode 28 loads low then high pointer from aligned word pair.
// - Opcodes 4k and Ek load the immediate into work or low pointer.
// - Opcode 33 loads low table nibble into work, sets zero, three cycles.
// - Opcode 32 loads high table nibble into work, then bumps table pointer.
// - Opcode 0F stores work nibble at pointer address in one cycle.
// - Opcode 3F stores work nibble at direct address, two cycles.
// - Opcode 2D stores immediate into page-0 word given by address field.
// - Opcodes 10 and 11 copy high or low pointer into work, set zero.
// - Opcodes 30 and 31 swap work with high or low pointer, set zero.
// - Opcode 13 swaps work with the interrupt enable mask.
// - Opcode 29 swaps both pointers with aligned data word pair.
// - Compare Dk: immediate minus work, carry not-borrow, zero, condition not-zero.
// - Opcode 08 increments work, zero updated, condition is not-carry, carry kept.
// - Opcode 18 increments low pointer, zero updated, condition from carry.
// - Opcode 19 decrements low pointer, zero updated, condition is not-borrow.
// - Opcode 15 adds memory and carry to work, carry gets carry out.
// - Opcode 17 adds memory to work, carry kept, condition is carry out.
package nibble_core_pkg;
  localparam int PC_W = 12;
  localparam int DA_W = 8;
  localparam int DC_W = 12;
  localparam logic [7:0] OP_LD_A_HL = 8'h0c;
  localparam logic [7:0] OP_LD_A_X = 8'h3c;
  localparam logic [7:0] OP_LD_HL_X = 8'h28;
  localparam logic [7:0] OP_LDL = 8'h33;
  localparam logic [7:0] OP_LDH = 8'h32;
  localparam logic [7:0] OP_ST_HL = 8'h0f;
  localparam logic [7:0] OP_ST_X = 8'h3f;
  localparam logic [7:0] OP_ST_K_Y = 8'h2d;
  localparam logic [7:0] OP_MOV_H = 8'h10;
  localparam logic [7:0] OP_MOV_L = 8'h11;
  localparam logic [7:0] OP_XCH_H = 8'h30;
  localparam logic [7:0] OP_XCH_L = 8'h31;
  localparam logic [7:0] OP_XCH_EIR = 8'h13;
  localparam logic [7:0] OP_XCH_A_HL = 8'h0d;
  localparam logic [7:0] OP_XCH_A_X = 8'h3d;
  localparam logic [7:0] OP_XCH_HL_X = 8'h29;
  localparam logic [7:0] OP_INC_A = 8'h08;
  localparam logic [7:0] OP_INC_L = 8'h18;
  localparam logic [7:0] OP_DEC_L = 8'h19;
  localparam logic [7:0] OP_ADD_WITH_CARRY = 8'h15;
  localparam logic [7:0] OP_ADD = 8'h17;
  localparam logic [3:0] HI_LD_A_K = 4'h4;
  localparam logic [3:0] HI_LD_H_K = 4'hc;
  localparam logic [3:0] HI_LD_L_K = 4'he;
  localparam logic [3:0] HI_COMPARE_REVERSE_K = 4'hd;
  localparam logic [1:0] PAIR_MASK = 2'h0;
  localparam logic [3:0] PAGE0 = 4'h0;
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;

  typedef struct packed {
    logic [3:0] work;
    logic [3:0] high;
    logic [3:0] low;
    logic carry;
    logic zero;
    logic cond;
  } core_regs_t;

  typedef struct packed {
    logic we;
    logic [DA_W-1:0] addr;
    logic [3:0] wdata;
  } dmem_req_t;
endpackage

//--- rtl/nibble_data_ram.sv
// 256 x 4 data memory with registered read data.
// Assumes read address is presented one cycle before data is used.
`timescale 1ns/1ns
module nibble_data_ram (
  input wire logic CLK,
  input wire nibble_core_pkg::dmem_req_t REQ,
  output logic [3:0] RDATA
);
  import nibble_core_pkg::*;
  logic [3:0] mem [0:(1<<DA_W)-1];

  always_ff @(posedge CLK) begin
    if (REQ.we) begin
      mem[REQ.addr] <= REQ.wdata;
    end
    RDATA <= mem[REQ.addr];
  end
endmodule

//--- rtl/nibble_alu.sv
// Four-bit adder for add, increment, decrement and compare.
// Purely combinational; flags are chosen by the caller.
`timescale 1ns/1ns
module nibble_alu (
  input wire logic [3:0] A,
  input wire logic [3:0] B,
  input wire logic CIN,
  input wire logic SUB,
  output logic [3:0] SUM,
  output logic COUT
);
  logic [4:0] full;

  always_comb begin
    // Subtract as A + ~B + 1; COUT is then not-borrow
    full = {1'b0, A} + {1'b0, (SUB ? ~B : B)} + {4'h0, CIN};
    SUM = full[3:0];
    COUT = full[4];
  end
endmodule

//--- rtl/nibble_core_decode.sv
// Decode and execute for move, table, compare, increment and add groups.
// Assumes synchronous program memory returning data one cycle after address.
`timescale 1ns/1ns
module nibble_core_decode (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] PROG_DATA,
  input wire logic [nibble_core_pkg::DC_W-1:0] TABLE_PTR_INIT,
  input wire logic TABLE_PTR_LOAD,
  output logic [nibble_core_pkg::PC_W-1:0] PROG_ADDR,
  output logic [3:0] WORK,
  output logic [3:0] HIGH_PTR,
  output logic [3:0] LOW_PTR,
  output logic CARRY,
  output logic ZERO,
  output logic COND,
  output logic [3:0] IRQ_MASK,
  output logic [nibble_core_pkg::DC_W-1:0] TABLE_PTR,
  output logic BUSY
);
  import nibble_core_pkg::*;

  // Fetch issues address; next cycle the byte appears
  typedef enum {S_FETCH, S_DECODE, S_OPER, S_EXEC2, S_TABLE, S_PAIR} state_t;

  state_t state, next_state;
  core_regs_t r, next_r;
  logic [PC_W-1:0] pc, next_pc;
  logic [7:0] op, next_op;
  logic [7:0] operand, next_operand;
  logic [3:0] irq_mask, next_irq_mask;
  logic [DC_W-1:0] tptr, next_tptr;
  logic [3:0] pair_word, next_pair_word;
  dmem_req_t dreq;
  logic [3:0] rdata;
  logic [3:0] alu_a, alu_b, alu_sum;
  logic alu_cin, alu_sub, alu_cout;

  function automatic logic [DA_W-1:0] pair_base(input logic [7:0] x);
    pair_base = {x[7:2], PAIR_MASK};
  endfunction

  function automatic logic two_byte(input logic [7:0] o);
    two_byte = (o == OP_LD_A_X) || (o == OP_LD_HL_X) || (o == OP_ST_X) ||
      (o == OP_ST_K_Y) || (o == OP_XCH_A_X) || (o == OP_XCH_HL_X) ||
      (o == 8'h38) || (o == 8'h2e) || (o == 8'h3e);
  endfunction

  function automatic logic needs_mem(input logic [7:0] o);
    needs_mem = (o == OP_LD_A_HL) || (o == OP_XCH_A_HL) || (o == OP_ADD_WITH_CARRY) ||
      (o == OP_ADD);
  endfunction

  nibble_data_ram u_ram (
    .CLK(CLK),
    .REQ(dreq),
    .RDATA(rdata)
  );

  nibble_alu u_alu (
    .A(alu_a),
    .B(alu_b),
    .CIN(alu_cin),
    .SUB(alu_sub),
    .SUM(alu_sum),
    .COUT(alu_cout)
  );

  always_comb begin
    next_state = state;
    next_r = r;
    next_pc = pc;
    next_op = op;
    next_operand = operand;
    next_irq_mask = irq_mask;
    next_tptr = tptr;
    next_pair_word = pair_word;
    dreq = '0;
    dreq.addr = {r.high, r.low};
    alu_a = r.work;
    alu_b = rdata;
    alu_cin = 1'b0;
    alu_sub = 1'b0;
    case (state)
      S_FETCH: begin
        next_pc = pc + 12'h001;
        next_state = S_DECODE;
        // Deferred low-word write of the pair swap; single-port memory
        if (op == OP_XCH_HL_X) begin
          dreq.we = 1'b1;
          dreq.addr = pair_base(operand);
          dreq.wdata = pair_word;
        end
      end
      S_DECODE: begin
        next_op = PROG_DATA;
        if (two_byte(PROG_DATA)) begin
          next_pc = pc + 12'h001;
          next_state = S_OPER;
        end else if (needs_mem(PROG_DATA) || PROG_DATA == OP_LDL ||
            PROG_DATA == OP_LDH) begin
          next_state = S_EXEC2;
        end else begin
          next_state = S_FETCH;
          case (PROG_DATA[7:4])
            HI_LD_A_K: next_r.work = PROG_DATA[3:0];
            HI_LD_L_K: next_r.low = PROG_DATA[3:0];
            HI_LD_H_K: next_r.high = PROG_DATA[3:0];
            HI_COMPARE_REVERSE_K: begin
              alu_a = PROG_DATA[3:0];
              alu_b = r.work;
              alu_sub = 1'b1;
              alu_cin = 1'b1;
              next_r.carry = alu_cout;
              next_r.zero = (alu_sum == 4'h0);
              next_r.cond = (alu_sum != 4'h0);
            end
            default: begin
              case (PROG_DATA)
                OP_ST_HL: begin
                  dreq.we = 1'b1;
                  dreq.wdata = r.work;
                end
                OP_MOV_H: begin
                  next_r.work = r.high;
                  next_r.zero = (r.high == 4'h0);
                end
                OP_MOV_L: begin
                  next_r.work = r.low;
                  next_r.zero = (r.low == 4'h0);
                end
                OP_XCH_H: begin
                  next_r.work = r.high;
                  next_r.high = r.work;
                  next_r.zero = (r.high == 4'h0);
                end
                OP_XCH_L: begin
                  next_r.work = r.low;
                  next_r.low = r.work;
                  next_r.zero = (r.low == 4'h0);
                end
                OP_XCH_EIR: begin
                  next_r.work = irq_mask;
                  next_irq_mask = r.work;
                end
                OP_INC_A: begin
                  alu_b = 4'h0;
                  alu_cin = 1'b1;
                  next_r.work = alu_sum;
                  next_r.zero = (alu_sum == 4'h0);
                  next_r.cond = ~alu_cout;
                end
                OP_INC_L: begin
                  alu_a = r.low;
                  alu_b = 4'h0;
                  alu_cin = 1'b1;
                  next_r.low = alu_sum;
                  next_r.zero = (alu_sum == 4'h0);
                  next_r.cond = alu_cout;
                end
                OP_DEC_L: begin
                  alu_a = r.low;
                  alu_b = 4'h1;
                  alu_sub = 1'b1;
                  alu_cin = 1'b1;
                  next_r.low = alu_sum;
                  next_r.zero = (alu_sum == 4'h0);
                  next_r.cond = alu_cout;
                end
                default: ;
              endcase
            end
          endcase
        end
      end
      S_OPER: begin
        next_operand = PROG_DATA;
        next_state = S_EXEC2;
        case (op)
          OP_LD_A_X, OP_XCH_A_X: dreq.addr = PROG_DATA;
          OP_LD_HL_X, OP_XCH_HL_X: dreq.addr = pair_base(PROG_DATA);
          OP_ST_X: begin
            dreq.we = 1'b1;
            dreq.addr = PROG_DATA;
            dreq.wdata = r.work;
            next_state = S_FETCH;
          end
          OP_ST_K_Y: begin
            dreq.we = 1'b1;
            dreq.addr = {PAGE0, PROG_DATA[3:0]};
            dreq.wdata = PROG_DATA[7:4];
            next_state = S_FETCH;
          end
          default: next_state = S_FETCH;
        endcase
      end
      S_EXEC2: begin
        next_state = S_FETCH;
        case (op)
          OP_LD_A_HL: next_r.work = rdata;
          OP_XCH_A_HL: begin
            next_r.work = rdata;
            dreq.we = 1'b1;
            dreq.wdata = r.work;
          end
          OP_ADD_WITH_CARRY: begin
            alu_cin = r.carry;
            next_r.work = alu_sum;
            next_r.carry = alu_cout;
            next_r.zero = (alu_sum == 4'h0);
            next_r.cond = alu_cout;
          end
          OP_ADD: begin
            next_r.work = alu_sum;
            next_r.zero = (alu_sum == 4'h0);
            next_r.cond = alu_cout;
          end
          OP_LD_A_X: next_r.work = rdata;
          OP_XCH_A_X: begin
            next_r.work = rdata;
            dreq.we = 1'b1;
            dreq.addr = operand;
            dreq.wdata = r.work;
          end
          OP_LD_HL_X: begin
            next_r.low = rdata;
            dreq.addr = pair_base(operand) + 8'h01;
            next_state = S_PAIR;
          end
          OP_XCH_HL_X: begin
            next_r.low = rdata;
            next_pair_word = r.low;
            dreq.addr = pair_base(operand) + 8'h01;
            next_state = S_PAIR;
          end
          OP_LDL, OP_LDH: begin
            next_pc = pc;
            next_state = S_TABLE;
          end
          default: ;
        endcase
      end
      S_PAIR: begin
        next_state = S_FETCH;
        dreq.addr = pair_base(operand) + 8'h01;
        next_r.high = rdata;
        if (op == OP_XCH_HL_X) begin
          dreq.we = 1'b1;
          dreq.wdata = r.high;
        end
      end
      S_TABLE: begin
        next_state = S_FETCH;
        if (op == OP_LDL) begin
          next_r.work = PROG_DATA[3:0];
        end else begin
          next_r.work = PROG_DATA[7:4];
          next_tptr = tptr + 12'h001;
        end
        next_r.zero = ((op == OP_LDL ? PROG_DATA[3:0] : PROG_DATA[7:4]) == 4'h0);
      end
      default: next_state = S_FETCH;
    endcase
    if (TABLE_PTR_LOAD) begin
      next_tptr = TABLE_PTR_INIT;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= S_FETCH;
      r <= '0;
      pc <= PC_RESET;
      op <= 8'h00;
      operand <= 8'h00;
      irq_mask <= 4'h0;
      tptr <= '0;
      pair_word <= 4'h0;
    end else begin
      state <= next_state;
      r <= next_r;
      pc <= next_pc;
      op <= next_op;
      operand <= next_operand;
      irq_mask <= next_irq_mask;
      tptr <= next_tptr;
      pair_word <= next_pair_word;
    end
  end

  // Table fetches borrow the program address; keeps one program port
  always_ff @(posedge CLK) begin
    if (RST) begin
      PROG_ADDR <= PC_RESET;
      BUSY <= 1'b0;
    end else begin
      // Table address must lead the table state by one cycle of memory latency
      PROG_ADDR <= (next_state == S_TABLE ||
          (next_state == S_EXEC2 && (next_op == OP_LDL || next_op == OP_LDH))) ?
          next_tptr : next_pc;
      BUSY <= (next_state != S_FETCH);
    end
  end

  assign WORK = r.work;
  assign HIGH_PTR = r.high;
  assign LOW_PTR = r.low;
  assign CARRY = r.carry;
  assign ZERO = r.zero;
  assign COND = r.cond;
  assign IRQ_MASK = irq_mask;
  assign TABLE_PTR = tptr;
endmodule

//--- test/prog_rom_model.sv
// Program memory model facing the nibble core decoder.
// Assumes a synchronous read: the byte appears one edge after the address.
`timescale 1ns/1ns
module prog_rom_model (
  input wire logic CLK,
  input wire logic [11:0] ADDR,
  output logic [7:0] DATA
);
  logic [7:0] mem [0:4095];

  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    DATA = 8'h00;
  end

  always @(posedge CLK) begin
    DATA <= mem[ADDR];
  end
endmodule

//--- test/nibble_core_decode_asserts.sv
// Port-level checker for the nibble core decoder, bound to its top module.
// Assumes the opcode stands on PROG_DATA the cycle after BUSY is low.
`timescale 1ns/1ns
module nibble_core_decode_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] PROG_DATA,
  input wire logic [nibble_core_pkg::DC_W-1:0] TABLE_PTR_INIT,
  input wire logic TABLE_PTR_LOAD,
  input wire logic [nibble_core_pkg::PC_W-1:0] PROG_ADDR,
  input wire logic [3:0] WORK,
  input wire logic [3:0] HIGH_PTR,
  input wire logic [3:0] LOW_PTR,
  input wire logic CARRY,
  input wire logic ZERO,
  input wire logic COND,
  input wire logic [3:0] IRQ_MASK,
  input wire logic [nibble_core_pkg::DC_W-1:0] TABLE_PTR,
  input wire logic BUSY
);
  import nibble_core_pkg::*;
  logic [1:0] live;
  logic [1:0] next_live;
  logic dec;
  logic fetch_q, next_fetch_q;

  always_comb begin
    next_fetch_q = !BUSY;
    next_live = live;
    if (RST) next_live = 2'h0;
    else if (live != 2'h3) next_live = live + 2'h1;
  end

  always_ff @(posedge CLK) begin
    live <= next_live;
    fetch_q <= next_fetch_q;
  end

  // Decode is the cycle after fetch; stale bytes after reset are skipped
  assign dec = fetch_q && live >= 2'h2;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  ld_work_a: assert property (
    dec && PROG_DATA[7:4] == HI_LD_A_K |=> WORK == $past(PROG_DATA[3:0]))
    else $error("immediate not loaded into work");
  ld_low_a: assert property (
    dec && PROG_DATA[7:4] == HI_LD_L_K |=> LOW_PTR == $past(PROG_DATA[3:0]))
    else $error("immediate not loaded into low pointer");
  mov_high_a: assert property (
    dec && PROG_DATA == OP_MOV_H |=> WORK == $past(HIGH_PTR) && ZERO == ($past(HIGH_PTR) == 4'h0))
    else $error("high pointer copy wrong");
  inc_work_a: assert property (
    dec && PROG_DATA == OP_INC_A |=> WORK == $past(WORK) + 4'h1 && CARRY == $past(CARRY)
      && COND == ($past(WORK) != 4'hf)) else $error("work increment wrong");
  inc_low_a: assert property (
    dec && PROG_DATA == OP_INC_L |=> LOW_PTR == $past(LOW_PTR) + 4'h1
      && COND == ($past(LOW_PTR) == 4'hf)) else $error("low pointer increment wrong");
  dec_low_a: assert property (
    dec && PROG_DATA == OP_DEC_L |=> LOW_PTR == $past(LOW_PTR) - 4'h1
      && COND == ($past(LOW_PTR) != 4'h0)) else $error("low pointer decrement wrong");
  cmp_flags_a: assert property (
    dec && PROG_DATA[7:4] == HI_COMPARE_REVERSE_K |=> $stable(WORK)
      && CARRY == ($past(PROG_DATA[3:0]) >= $past(WORK))
      && COND == ($past(PROG_DATA[3:0]) != $past(WORK))) else $error("compare flags wrong");
  tptr_load_a: assert property (
    TABLE_PTR_LOAD |=> TABLE_PTR == $past(TABLE_PTR_INIT))
    else $error("table pointer not loaded");
  tptr_step_a: assert property (
    !$past(TABLE_PTR_LOAD) && !$past(RST) && TABLE_PTR != $past(TABLE_PTR)
      |-> TABLE_PTR == $past(TABLE_PTR) + 12'h001) else $error("table pointer jumped");

  cov_cmp: cover property (dec && PROG_DATA[7:4] == HI_COMPARE_REVERSE_K);
  cov_inc_wrap: cover property (dec && PROG_DATA == OP_INC_A ##1 COND == 1'b0);
  cov_tptr: cover property (TABLE_PTR_LOAD ##1 !TABLE_PTR_LOAD);
endmodule

bind nibble_core_decode nibble_core_decode_chk chk (
  .CLK, .RST, .PROG_DATA, .TABLE_PTR_INIT, .TABLE_PTR_LOAD, .PROG_ADDR, .WORK,
  .HIGH_PTR, .LOW_PTR, .CARRY, .ZERO, .COND, .IRQ_MASK, .TABLE_PTR, .BUSY);

//--- test/nibble_core_decode_tb.sv
// Self-checking bench for the nibble core decoder with a program memory model.
// Assumes fetch starts at address 0 after reset and byte 00 runs as a no-op.
`timescale 1ns/1ns
module nibble_core_decode_tb;
  import nibble_core_pkg::*;
  typedef struct packed {
    logic [95:0] prog;
    logic [11:0] tp;
    core_regs_t exp;
    logic [2:0] fm;
    logic [3:0] irq;
    logic [11:0] tptr;
  } row_t;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] PROG_DATA;
  logic [DC_W-1:0] TABLE_PTR_INIT = '0;
  logic TABLE_PTR_LOAD = 1'b0;
  logic [PC_W-1:0] PROG_ADDR;
  logic [DC_W-1:0] TABLE_PTR;
  logic [3:0] WORK, HIGH_PTR, LOW_PTR, IRQ_MASK;
  logic CARRY, ZERO, COND, BUSY;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  row_t rows[$];

  nibble_core_decode DUT (.CLK, .RST, .PROG_DATA, .TABLE_PTR_INIT, .TABLE_PTR_LOAD,
    .PROG_ADDR, .WORK, .HIGH_PTR, .LOW_PTR, .CARRY, .ZERO, .COND, .IRQ_MASK,
    .TABLE_PTR, .BUSY);
  prog_rom_model rom (.CLK, .ADDR(PROG_ADDR), .DATA(PROG_DATA));

  always #10 CLK = ~CLK;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #2;
  endtask

  task automatic row(input logic [95:0] p, input logic [11:0] tp, input logic [14:0] e,
      input logic [2:0] fm, input logic [3:0] ir, input logic [11:0] tq);
    rows.push_back({p, tp, e, fm, ir, tq});
  endtask

  // Programs sit right-aligned in bytes 1..12; leading zeros are no-ops
  task automatic run(input row_t r);
    int k;
    logic [14:0] m;
    RST = 1'b1;
    for (k = 0; k < 12; k++) rom.mem[k + 1] = r.prog[8 * (11 - k) +: 8];
    tick(5);
    RST = 1'b0;
    TABLE_PTR_INIT = r.tp;
    TABLE_PTR_LOAD = 1'b1;
    tick(1);
    TABLE_PTR_LOAD = 1'b0;
    k = 0;
    while (!(PROG_ADDR === 12'd15 && BUSY === 1'b0) && k < 200) begin
      tick(1);
      k++;
    end
    chk(k < 200, 1'b1);
    tick(3);
    m = {12'hfff, r.fm};
    chk({WORK, HIGH_PTR, LOW_PTR, CARRY, ZERO, COND} & m, r.exp & m);
    chk(IRQ_MASK, r.irq);
    chk(TABLE_PTR, r.tptr);
  endtask

  initial begin
    rom.mem[12'h080] = 8'h5a;
    rom.mem[12'h081] = 8'h30;
    rom.mem[12'hfff] = 8'hc0;
    row(96'h45e9cc10, '0, {4'hc, 4'hc, 4'h9, 3'b000}, 3'b010, '0, '0);
    row(96'he04511, '0, {4'h0, 4'h0, 4'h0, 3'b010}, 3'b010, '0, '0);
    row(96'h43c730, '0, {4'h7, 4'h3, 4'h0, 3'b000}, 3'b010, '0, '0);
    row(96'h43e031, '0, {4'h0, 4'h0, 4'h3, 3'b010}, 3'b010, '0, '0);
    row(96'h43d5, '0, {4'h3, 4'h0, 4'h0, 3'b101}, 3'b111, '0, '0);
    row(96'h45d5, '0, {4'h5, 4'h0, 4'h0, 3'b110}, 3'b111, '0, '0);
    row(96'h46d5, '0, {4'h6, 4'h0, 4'h0, 3'b001}, 3'b111, '0, '0);
    row(96'h40d04f08, '0, {4'h0, 4'h0, 4'h0, 3'b110}, 3'b111, '0, '0);
    row(96'hef18, '0, {4'h0, 4'h0, 4'h0, 3'b011}, 3'b111, '0, '0);
    row(96'he019, '0, {4'h0, 4'h0, 4'hf, 3'b000}, 3'b111, '0, '0);
    row(96'he2c14b0f40d04415, '0, {4'h0, 4'h1, 4'h2, 3'b111}, 3'b111, '0, '0);
    row(96'he2c1450f40d04917, '0, {4'he, 4'h1, 4'h2, 3'b100}, 3'b111, '0, '0);
    row(96'h463f12e2c1400c, '0, {4'h6, 4'h1, 4'h2, 3'b000}, 3'b000, '0, '0);
    row(96'h2d73e3c00c, '0, {4'h7, 4'h0, 4'h3, 3'b000}, 3'b000, '0, '0);
    row(96'h453f144a3f15e1c229162817, '0, {4'ha, 4'h2, 4'h1, 3'b000}, 3'b000, '0, '0);
    row(96'h453f144a3f15e1c22916, '0, {4'ha, 4'ha, 4'h5, 3'b000}, 3'b000, '0, '0);
    row(96'h333233, 12'h080, {4'h0, 4'h0, 4'h0, 3'b010}, 3'b010, '0, 12'h081);
    row(96'h32, 12'hfff, {4'hc, 4'h0, 4'h0, 3'b000}, 3'b000, '0, 12'h000);
    row(96'h4a13, '0, {4'h0, 4'h0, 4'h0, 3'b000}, 3'b000, 4'ha, '0);
    foreach (rows[i]) run(rows[i]);
    // One-edge reset mid-run must clear every register
    RST = 1'b1;
    tick(1);
    chk({WORK, HIGH_PTR, LOW_PTR, CARRY, ZERO, COND, IRQ_MASK}, 32'h0);
    chk(TABLE_PTR, 32'h0);
    RST = 1'b0;
    print_verdict();
  end
endmodule
